// >>> src/fpu_pkg.sv
`default_nettype none

package fpu_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets

	localparam logic [7:0] OFF_MSTATE = 8'h00;
	localparam logic [7:0] OFF_FSCR   = 8'h04;
	localparam logic [7:0] OFF_CMD    = 8'h08;
	localparam logic [7:0] OFF_A_LO   = 8'h0c;
	localparam logic [7:0] OFF_A_HI   = 8'h10;
	localparam logic [7:0] OFF_B_LO   = 8'h14;
	localparam logic [7:0] OFF_B_HI   = 8'h18;
	localparam logic [7:0] OFF_C_LO   = 8'h1c;
	localparam logic [7:0] OFF_C_HI   = 8'h20;
	localparam logic [7:0] OFF_D_LO   = 8'h24;
	localparam logic [7:0] OFF_D_HI   = 8'h28;
	localparam logic [7:0] OFF_COND   = 8'h2c;
	localparam logic [7:0] OFF_STAT   = 8'h30;
	localparam logic [7:0] OFF_ICLR   = 8'h34;
	localparam logic [7:0] OFF_IEN    = 8'h38;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and exception vector

	localparam logic [2:0]  FSCR_RST       = 3'h0;
	localparam logic [5:0]  IEN_RST        = 6'h00;
	localparam logic [19:0] UNAVAIL_VECTOR = 20'h00800;

	////////////////////////////////////////////////////////////////////////////////
	// Number format constants (biased exponents, working mantissa lead at bit 55)

	localparam logic signed [13:0] EXP_BIAS = 14'sh03ff;
	localparam logic signed [13:0] EXP_ZERO = 14'sh3800;
	localparam logic signed [13:0] EMIN_D   = 14'sh0001;
	localparam logic signed [13:0] EMAX_D   = 14'sh07fe;
	localparam logic signed [13:0] EMIN_S   = 14'sh0381;
	localparam logic signed [13:0] EMAX_S   = 14'sh047e;
	localparam logic [5:0]         LSB_D    = 6'h03;
	localparam logic [5:0]         LSB_S    = 6'h20;
	localparam logic [10:0]        EXP_ALL1 = 11'h7ff;
	localparam logic [51:0]        MAXF_D   = 52'hfffffffffffff;
	localparam logic [51:0]        MAXF_S   = 52'hfffffe0000000;
	localparam logic [63:0]        QNAN     = 64'h7ff8000000000000;
	localparam logic [63:0]        QUIET    = 64'h0008000000000000;
	localparam logic [63:0]        SGL_DROP = 64'h000000001fffffff;

	////////////////////////////////////////////////////////////////////////////////
	// Types

	typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_BAD} fpu_op_t;
	typedef enum logic [1:0] {RM_NEAR, RM_ZERO, RM_PINF, RM_NINF} fpu_rm_t;

	typedef struct packed {
		logic    non_ieee_mode_bit;
		fpu_rm_t rounding_control_field;
	} fpu_fscr_t;

	typedef struct packed {
		logic    dot;
		logic    sgl;
		fpu_op_t op;
	} fpu_cmd_t;

	typedef struct packed {
		logic xx;
		logic ux;
		logic ox;
		logic vx;
		logic unav;
		logic done;
	} fpu_stat_t;

	typedef struct packed {
		logic               sgn;
		logic signed [13:0] exp;
		logic [56:0]        man;
	} fpu_work_t;

endpackage

`default_nettype wire

// >>> src/fpu_add_sub_mul.sv
// How it works
// RL1: Execute only while float enable bit set
// RL2: Disabled attempt raises unavailable exception, vector 0x00800
// RL3: Results follow IEEE-754 arithmetic
// RL4: Non-IEEE mode may flush denormals
// RL5: Double add: sum, normalize, round double
// RL6: Single add: same, rounded to single
// RL7: Double subtract: A minus B, round double
// RL8: Single subtract: A minus B, round single
// RL9: Double multiply: A times C product
// RL10: Dotted form alone updates condition register
// RL11: Product normalized and rounded like sums
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module fpu_add_sub_mul (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic [7:0]                avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	input  wire logic                      ls_attempt,
	output logic                           ls_grant,
	output logic                           busy,
	output logic                           irq,
	output logic                           unavail_exc,
	output logic [19:0]                    unavail_vector,
	output logic                           cond_update,
	output logic [3:0]                     condition_register
);
	import fpu_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_NORM, S_ROUND, S_FIX} fpu_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Arithmetic helpers

	function automatic fpu_work_t unpack(input logic [63:0] x, input logic ni);
		fpu_work_t u;
		u.sgn = x[63];
		u.exp = (x[62:52] == 11'h000) ? EMIN_D : {3'h0, x[62:52]};
		u.man = {1'b0, x[62:52] != 11'h000, x[51:0], 3'h0};
		if (ni && x[62:52] == 11'h000) begin
			u.man = '0; // RL4
		end
		for (int i = 0; i < 53; i++) begin
			if (!u.man[55] && u.man != '0) begin
				u.man = u.man << 1;
				u.exp = u.exp - 14'sh0001;
			end
		end
		// Zero sits far below any operand so alignment never shifts the other away
		if (u.man == '0) begin
			u.exp = EXP_ZERO;
		end
		return u;
	endfunction

	function automatic logic [56:0] shr(input logic [56:0] m, input logic [13:0] n);
		logic [56:0] lost;
		lost = m & ~({57{1'b1}} << n);
		if (n > 14'h0038) begin
			return {56'h0, |m};
		end
		return (m >> n) | {56'h0, |lost};
	endfunction

	function automatic fpu_work_t add_core(input fpu_work_t a, input fpu_work_t b,
			input logic neg_zero);
		fpu_work_t   big;
		fpu_work_t   sml;
		fpu_work_t   r;
		logic [56:0] s;
		logic        a_big;
		a_big = (a.exp > b.exp) || (a.exp == b.exp && a.man >= b.man);
		big   = a_big ? a : b;
		sml   = a_big ? b : a;
		s     = shr(sml.man, 14'(big.exp - sml.exp));
		r.exp = big.exp;
		r.sgn = big.sgn;
		if (big.sgn == sml.sgn) begin
			r.man = big.man + s;
		end else begin
			r.man = big.man - s;
			if (r.man == '0) begin
				r.sgn = neg_zero; // RL3
			end
		end
		return r;
	endfunction

	function automatic fpu_work_t mul_core(input fpu_work_t a, input fpu_work_t c);
		fpu_work_t    r;
		logic [105:0] p;
		p     = a.man[55:3] * c.man[55:3];
		r.sgn = a.sgn ^ c.sgn;
		r.exp = a.exp + c.exp - EXP_BIAS;
		r.man = {p[105:50], |p[49:0]};
		return r;
	endfunction

	function automatic logic is_nan(input logic [63:0] x);
		return (&x[62:52]) && (|x[51:0]);
	endfunction

	function automatic logic is_inf(input logic [63:0] x);
		return (&x[62:52]) && !(|x[51:0]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic        float_enable_bit, ack, ni, ux_q, xx_q;
	fpu_fscr_t   float_status_control_reg;
	fpu_cmd_t    cmd;
	fpu_stat_t   stat, ien;
	logic [63:0] first_source_reg, second_source_reg, multiplier_source_reg, destination_reg;
	fpu_state_t  state;
	fpu_work_t   w;
	fpu_rm_t     rm;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic        req, stall, wr_fire, cmd_wr;
	logic [31:0] rd_mux;
	fpu_cmd_t    cmd_in;

	assign req     = avs_read | avs_write;
	// A new command waits while one is in flight; operand writes are never held
	assign stall   = avs_write && avs_address == OFF_CMD && state != S_IDLE;
	assign avs_waitrequest = req & ~ack;
	assign wr_fire = avs_write & ack;
	assign cmd_wr  = wr_fire && avs_address == OFF_CMD;
	assign cmd_in  = fpu_cmd_t'(avs_writedata[3:0]);

	assign rd_mux =
		(avs_address == OFF_MSTATE) ? {31'h0, float_enable_bit} :
		(avs_address == OFF_FSCR)   ? {29'h0, float_status_control_reg} :
		(avs_address == OFF_CMD)    ? {28'h0, cmd} :
		(avs_address == OFF_A_LO)   ? first_source_reg[31:0] :
		(avs_address == OFF_A_HI)   ? first_source_reg[63:32] :
		(avs_address == OFF_B_LO)   ? second_source_reg[31:0] :
		(avs_address == OFF_B_HI)   ? second_source_reg[63:32] :
		(avs_address == OFF_C_LO)   ? multiplier_source_reg[31:0] :
		(avs_address == OFF_C_HI)   ? multiplier_source_reg[63:32] :
		(avs_address == OFF_D_LO)   ? destination_reg[31:0] :
		(avs_address == OFF_D_HI)   ? destination_reg[63:32] :
		(avs_address == OFF_COND)   ? {28'h0, condition_register} :
		(avs_address == OFF_STAT)   ? {26'h0, stat} :
		(avs_address == OFF_IEN)    ? {26'h0, ien} : 32'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Issue and special operands

	logic        is_mul, is_sub, start, unav_try;
	logic [63:0] src2, b_eff, spec_val;
	fpu_work_t   ua, u2, core;
	logic        a_nan, b_nan, a_inf, b_inf, spec_hit, bad_op, spec_vx;

	assign is_mul   = cmd_in.op == OP_MUL;
	assign is_sub   = cmd_in.op == OP_SUB;
	assign start    = cmd_wr && float_enable_bit && cmd_in.op != OP_BAD; // RL1
	assign unav_try = (cmd_wr | ls_attempt) & ~float_enable_bit; // RL2
	assign ls_grant = ls_attempt & float_enable_bit; // RL1
	assign src2     = is_mul ? multiplier_source_reg : second_source_reg; // RL9
	assign b_eff    = src2 ^ {is_sub, 63'h0}; // RL7 RL8
	assign ua       = unpack(first_source_reg, float_status_control_reg.non_ieee_mode_bit);
	assign u2       = unpack(b_eff, float_status_control_reg.non_ieee_mode_bit);
	assign core     = is_mul ? mul_core(ua, u2) :
		add_core(ua, u2, float_status_control_reg.rounding_control_field == RM_NINF); // RL5

	assign a_nan    = is_nan(first_source_reg);
	assign b_nan    = is_nan(src2);
	assign a_inf    = is_inf(first_source_reg);
	assign b_inf    = is_inf(src2);
	assign spec_hit = a_nan | b_nan | a_inf | b_inf;
	assign bad_op   = is_mul ? ((a_inf && u2.man == '0) || (b_inf && ua.man == '0)) :
		(a_inf && b_inf && first_source_reg[63] != b_eff[63]);
	assign spec_vx  = (a_nan && !first_source_reg[51]) || (b_nan && !src2[51]) || bad_op; // RL3
	assign spec_val = (a_nan ? (first_source_reg | QUIET) :
		b_nan ? (src2 | QUIET) :
		bad_op ? QNAN :
		is_mul ? {first_source_reg[63] ^ src2[63], a_inf ? first_source_reg[62:0] : src2[62:0]} :
		a_inf ? first_source_reg : b_eff) & ~(cmd_in.sgl ? SGL_DROP : 64'h0); // RL3

	////////////////////////////////////////////////////////////////////////////////
	// Rounding and packing of the working value

	logic signed [13:0] emin, emax;
	logic [5:0]         lsb;
	logic [56:0]        inc, lowm, rem, rounded;
	logic               rnd_up, flush, ovf, to_inf, fin, done_now, dot_now;
	logic [63:0]        pack_val;
	fpu_stat_t          ev, clr;

	assign emin    = cmd.sgl ? EMIN_S : EMIN_D;
	assign emax    = cmd.sgl ? EMAX_S : EMAX_D;
	assign lsb     = cmd.sgl ? LSB_S : LSB_D; // RL5 RL6
	assign inc     = 57'h1 << lsb;
	assign lowm    = inc - 57'h1;
	assign rem     = w.man & lowm;
	assign rnd_up  = (rm == RM_NEAR) ? (rem > (inc >> 1) || (rem == (inc >> 1) && |(w.man & inc))) :
		(rm == RM_PINF) ? (!w.sgn && |rem) :
		(rm == RM_NINF) ? (w.sgn && |rem) : 1'b0; // RL3
	// Non-IEEE mode trades gradual underflow for a flushed zero
	assign flush   = ni && !w.man[55] && w.man != '0; // RL4
	assign rounded = flush ? '0 : (w.man & ~lowm) + (rnd_up ? inc : '0);
	assign ovf     = w.exp > emax;
	assign to_inf  = rm == RM_NEAR || (rm == RM_PINF && !w.sgn) || (rm == RM_NINF && w.sgn);
	assign pack_val = ovf ? (to_inf ? {w.sgn, EXP_ALL1, 52'h0} :
		{w.sgn, emax[10:0], cmd.sgl ? MAXF_S : MAXF_D}) :
		{w.sgn, w.man[55] ? w.exp[10:0] : 11'h000, w.man[54:3]}; // RL3

	assign fin      = state == S_FIX && !w.man[56] &&
		!(cmd.sgl && !w.man[55] && w.man != '0);
	assign done_now = fin | (start & spec_hit);
	assign dot_now  = start ? cmd_in.dot : cmd.dot;

	assign ev.done  = done_now;
	assign ev.unav  = unav_try;
	assign ev.vx    = start & spec_hit & spec_vx;
	assign ev.ox    = fin & ovf;
	assign ev.ux    = fin & ux_q;
	assign ev.xx    = fin & (xx_q | ovf);
	assign clr      = (wr_fire && avs_address == OFF_ICLR) ? avs_writedata[5:0] : '0;
	assign irq      = |(stat & ien);
	assign busy     = state != S_IDLE;

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	always_ff @(posedge clk) begin
		if (srst) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack <= req & ~ack & ~stall;
			if (req && !ack && !stall) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			float_enable_bit <= 1'b0;
			float_status_control_reg <= FSCR_RST;
			first_source_reg <= 64'h0;
			second_source_reg <= 64'h0;
			multiplier_source_reg <= 64'h0;
			ien <= IEN_RST;
		end else if (wr_fire) begin
			unique case (avs_address)
				OFF_MSTATE: float_enable_bit <= avs_writedata[0];
				OFF_FSCR:   float_status_control_reg <= avs_writedata[2:0];
				OFF_A_LO:   first_source_reg[31:0] <= avs_writedata;
				OFF_A_HI:   first_source_reg[63:32] <= avs_writedata;
				OFF_B_LO:   second_source_reg[31:0] <= avs_writedata;
				OFF_B_HI:   second_source_reg[63:32] <= avs_writedata;
				OFF_C_LO:   multiplier_source_reg[31:0] <= avs_writedata;
				OFF_C_HI:   multiplier_source_reg[63:32] <= avs_writedata;
				OFF_IEN:    ien <= avs_writedata[5:0];
				default: ;
			endcase
		end
	end

	// Set wins over a clear landing in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			stat <= '0;
			unavail_exc <= 1'b0;
			unavail_vector <= 20'h0;
			cond_update <= 1'b0;
			condition_register <= 4'h0;
		end else begin
			stat <= (stat & ~clr) | ev;
			unavail_exc <= unav_try; // RL2
			if (unav_try) begin
				unavail_vector <= UNAVAIL_VECTOR; // RL2
			end
			cond_update <= done_now & dot_now; // RL10
			if (done_now && dot_now) begin
				condition_register <= {ev.vx, ev.ox, ev.ux, ev.xx}; // RL10
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Execution sequence

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= S_IDLE;
			cmd <= '0;
			w <= '0;
			rm <= RM_NEAR;
			ni <= 1'b0;
			ux_q <= 1'b0;
			xx_q <= 1'b0;
			destination_reg <= 64'h0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (start) begin
						cmd <= cmd_in;
						rm <= float_status_control_reg.rounding_control_field;
						ni <= float_status_control_reg.non_ieee_mode_bit;
						w <= core;
						if (spec_hit) begin
							destination_reg <= spec_val; // RL3
						end else begin
							state <= S_NORM; // RL11
						end
					end
				end
				S_NORM: begin
					if (w.man[56]) begin
						w.man <= shr(w.man, 14'h0001);
						w.exp <= w.exp + 14'sh0001;
					end else if (w.exp < emin) begin
						w.man <= shr(w.man, 14'(emin - w.exp)); // RL3
						w.exp <= emin;
					end else if (!w.man[55] && w.man != '0 && w.exp > emin) begin
						w.man <= w.man << 1; // RL5 RL7
						w.exp <= w.exp - 14'sh0001;
					end else begin
						state <= S_ROUND;
					end
				end
				S_ROUND: begin
					w.man <= rounded; // RL5 RL6 RL7 RL8 RL11
					xx_q <= (|rem) | flush;
					ux_q <= !w.man[55] && ((|rem) || flush);
					state <= S_FIX;
				end
				S_FIX: begin
					if (w.man[56]) begin
						w.man <= w.man >> 1;
						w.exp <= w.exp + 14'sh0001;
					end else if (cmd.sgl && !w.man[55] && w.man != '0) begin
						// Single subnormals are normal numbers in the register format
						w.man <= w.man << 1; // RL6 RL8
						w.exp <= w.exp - 14'sh0001;
					end else begin
						destination_reg <= pack_val; // RL9
						state <= S_IDLE;
					end
				end
			endcase
		end
	end

endmodule // fpu_add_sub_mul

`default_nettype wire

// >>> tb/fpu_asm_checker.sv
`timescale 1ns/1ps
`default_nettype none

module fpu_asm_checker (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        ls_attempt,
	input wire logic        ls_grant,
	input wire logic        busy,
	input wire logic        irq,
	input wire logic        unavail_exc,
	input wire logic [19:0] unavail_vector,
	input wire logic        cond_update,
	input wire logic [3:0]  condition_register
);
	import fpu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the enable bit, rebuilt from completed bus writes

	logic en;
	logic seen;
	logic last_dot;
	wire  wr_done    = avs_write && !avs_waitrequest;
	wire  cmd_done   = wr_done && avs_address == OFF_CMD;
	wire  unav_cause = !en && (ls_attempt || cmd_done);

	always_ff @(posedge clk) begin
		if (srst) begin
			en <= 1'b0;
			seen <= 1'b0;
			last_dot <= 1'b0;
		end else begin
			if (wr_done && avs_address == OFF_MSTATE) en <= avs_writedata[0];
			if (cmd_done && en) last_dot <= avs_writedata[3];
			if (unavail_exc) seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	grant_gate_a: assert property (ls_grant == (ls_attempt && en))
		else $error("load/store grant disagrees with enable");
	no_exec_a: assert property (cmd_done && !en |=> !busy && !cond_update)
		else $error("operation ran while disabled");
	unav_pulse_a: assert property (unav_cause |=> unavail_exc)
		else $error("missing unavailable pulse");
	unav_cause_a: assert property (unavail_exc |-> $past(unav_cause))
		else $error("unavailable pulse without cause");
	vec_value_a: assert property (unavail_vector == ((seen || unavail_exc) ? UNAVAIL_VECTOR : 20'h00000))
		else $error("wrong exception vector");
	dot_only_a: assert property (cond_update |-> last_dot)
		else $error("condition update from plain op");
	cond_hold_a: assert property (!cond_update && !$past(srst) |-> $stable(condition_register))
		else $error("condition register changed silently");
	busy_bound_a: assert property ($rose(busy) |-> ##[1:150] !busy)
		else $error("operation never finished");

	cover property (unavail_exc);
	cover property (cond_update);
	cover property ($fell(busy));

endmodule // fpu_asm_checker

bind fpu_add_sub_mul fpu_asm_checker i_fpu_asm_checker (
	.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ls_attempt(ls_attempt), .ls_grant(ls_grant),
	.busy(busy), .irq(irq), .unavail_exc(unavail_exc), .unavail_vector(unavail_vector),
	.cond_update(cond_update), .condition_register(condition_register));

`default_nettype wire

// >>> tb/fpu_issue_model.sv
`timescale 1ns/1ps
`default_nettype none

// Issue side: one load/store attempt per request, grants counted
module fpu_issue_model (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic go,
	input  wire logic ls_grant,
	output logic      ls_attempt,
	output int        grants
);
	always_ff @(posedge clk) begin
		if (srst) begin
			ls_attempt <= 1'b0;
			grants <= 0;
		end else begin
			ls_attempt <= go;
			if (ls_attempt && ls_grant) grants <= grants + 1;
		end
	end
endmodule // fpu_issue_model

`default_nettype wire

// >>> tb/fpu_add_sub_mul_test.sv
`timescale 1ns/1ps
`default_nettype none

module fpu_add_sub_mul_test;
	import fpu_pkg::*;

	logic        clk, srst, avs_read, avs_write, go, avs_waitrequest;
	logic        ls_attempt, ls_grant, busy, irq, unavail_exc, cond_update;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, seed;
	logic [19:0] unavail_vector;
	logic [3:0]  condition_register;
	logic [63:0] d, a, b, c;
	int          err_count, compares, exc_n, cu_n, grants;

	fpu_add_sub_mul i_fpu_add_sub_mul (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ls_attempt(ls_attempt), .ls_grant(ls_grant), .busy(busy), .irq(irq),
		.unavail_exc(unavail_exc), .unavail_vector(unavail_vector),
		.cond_update(cond_update), .condition_register(condition_register));
	fpu_issue_model i_fpu_issue_model (.clk(clk), .srst(srst), .go(go), .ls_grant(ls_grant),
		.ls_attempt(ls_attempt), .grants(grants));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (unavail_exc === 1'b1) exc_n++;
		if (cond_update === 1'b1) cu_n++;
	end

	////////////////////////////////////////////////////////////////////////////////

	task check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Exponents kept close so sums and products are exact in double first
	function logic [63:0] rop(input logic s);
		logic [63:0] v;
		v = {rnd(), rnd()};
		v[62:55] = 8'h7f;
		if (s) v[28:0] = 29'h0;
		return v;
	endfunction

	// Nearest-even to 24 bits; valid since the double value is exact
	function logic [63:0] sgl(input logic [63:0] v);
		logic [63:0] t;
		t = v & ~SGL_DROP;
		if (v[28:0] > 29'h10000000 || (v[28:0] == 29'h10000000 && v[29])) t = t + 64'h20000000;
		return t;
	endfunction

	function logic [63:0] model(input int o, input logic s, input logic [63:0] x, y, z);
		real r;
		case (o)
			0: r = $bitstoreal(x) + $bitstoreal(y);
			1: r = $bitstoreal(x) - $bitstoreal(y);
			default: r = $bitstoreal(x) * $bitstoreal(z);
		endcase
		return s ? sgl($realtobits(r)) : $realtobits(r);
	endfunction

	task wait_ok;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 400);
		if (n >= 400) begin
			err_count++;
			$display("Error at %0t: bus stuck", $time);
		end
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] dt);
		avs_address <= ad;
		avs_writedata <= dt;
		avs_write <= 1'b1;
		wait_ok();
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task rdw(input logic [7:0] ad);
		avs_address <= ad;
		avs_read <= 1'b1;
		wait_ok();
		rd = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task op(input logic [3:0] cmd, input logic [63:0] x, y, z);
		int n;
		wr(OFF_A_LO, x[31:0]);
		wr(OFF_A_HI, x[63:32]);
		wr(OFF_B_LO, y[31:0]);
		wr(OFF_B_HI, y[63:32]);
		wr(OFF_C_LO, z[31:0]);
		wr(OFF_C_HI, z[63:32]);
		wr(OFF_CMD, {28'h0, cmd});
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) begin
			err_count++;
			$display("Error at %0t: operation stuck", $time);
		end
		rdw(OFF_D_LO);
		d[31:0] = rd;
		rdw(OFF_D_HI);
		d[63:32] = rd;
	endtask

	task attempt;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		#(40 * 30000);
		err_count++;
		$display("Error at %0t: timeout", $time);
		give_verdict();
	end

	initial begin
		seed = 32'h00017a33;
		{err_count, compares, exc_n, cu_n} = '0;
		{srst, avs_read, avs_write, go, avs_address, avs_writedata} <= {1'b1, 43'h0};
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdw(OFF_MSTATE);
		check(rd, 64'h0);
		rdw(OFF_FSCR);
		check(rd, 64'(FSCR_RST));
		wr(OFF_D_LO, 32'h12345678);
		rdw(OFF_D_LO);
		check(rd, 64'h0);
		rdw(8'hfc);
		check(rd, 64'h0);
		// Disabled command and load/store both refused
		wr(OFF_IEN, 32'h2);
		wr(OFF_CMD, 32'h8);
		@(posedge clk);
		check(64'(exc_n), 64'h1);
		check(irq, 1'b1);
		check(unavail_vector, 64'(UNAVAIL_VECTOR));
		check(cu_n, 0);
		attempt();
		check(64'(grants), 64'h0);
		check(64'(exc_n), 64'h2);
		rdw(OFF_STAT);
		check(rd[1], 1'b1);
		wr(OFF_IEN, 32'h0);
		check(irq, 1'b0);
		wr(OFF_IEN, 32'h2);
		wr(OFF_ICLR, 32'h2);
		check(irq, 1'b0);
		rdw(OFF_STAT);
		check(rd[1], 1'b0);
		wr(OFF_MSTATE, 32'h1);
		attempt();
		check(64'(grants), 64'h1);
		check(64'(exc_n), 64'h2);
		// Every rounding mode on a discarded tail, dotted forms
		for (int m = 0; m < 4; m++) begin
			wr(OFF_FSCR, m);
			op(4'h8, 64'h3ff0000000000000, 64'h3c30000000000000, 64'h0);
			check(d, 64'h3ff0000000000000 + (m == 2));
			check(condition_register, 4'h1);
			op(4'h9, 64'hbff0000000000000, 64'h3c30000000000000, 64'h0);
			check(d, 64'hbff0000000000000 + (m == 3));
			op(4'hc, 64'h3ff0000000000000, 64'h3e10000000000000, 64'h0);
			check(d, 64'h3ff0000000000000 + ((m == 2) ? 64'h20000000 : 64'h0));
			op(4'hd, 64'hbff0000000000000, 64'h3e10000000000000, 64'h0);
			check(d, 64'hbff0000000000000 + ((m == 3) ? 64'h20000000 : 64'h0));
			op(4'ha, 64'h3ff0000000000001, 64'h0, 64'h3ff0000000000001);
			check(d, 64'h3ff0000000000002 + (m == 2));
		end
		check(64'(cu_n), 64'h14);
		// Random plain ops against the model; no condition update allowed
		wr(OFF_FSCR, 32'h0);
		for (int i = 0; i < 24; i++) begin
			a = rop(i % 6 > 2);
			b = rop(i % 6 > 2);
			c = rop(i % 6 > 2);
			op({1'b0, i % 6 > 2, 2'(i % 3)}, a, b, c);
			check(d, model(i % 3, i % 6 > 2, a, b, c));
		end
		check(64'(cu_n), 64'h14);
		op(4'h9, 64'h7ff0000000000000, 64'h7ff0000000000000, 64'h0);
		check(d, QNAN);
		check(condition_register, 4'h8);
		op(4'h0, 64'h1, 64'h1, 64'h0);
		check(d, 64'h2);
		wr(OFF_FSCR, 32'h4);
		op(4'h0, 64'h1, 64'h1, 64'h0);
		check(d, 64'h0);
		// Overflow to infinity, then a tiny inexact product
		wr(OFF_FSCR, 32'h0);
		op(4'h8, 64'h7fefffffffffffff, 64'h7fefffffffffffff, 64'h0);
		check(d, 64'h7ff0000000000000);
		check(condition_register, 4'h5);
		op(4'ha, 64'h0010000000000001, 64'h0, 64'h3fe0000000000000);
		check(d, 64'h0008000000000000);
		check(condition_register, 4'h3);
		// Reserved op code must not start anything
		wr(OFF_CMD, 32'hb);
		check(busy, 1'b0);
		check(64'(cu_n), 64'h17);
		give_verdict();
	end
endmodule // fpu_add_sub_mul_test

`default_nettype wire
